// >>> src/fur_rx_top.sv
// Purpose: serial receive path with fifo, status flags and requests
// Assumes: AXI4-Lite master, one write and one read under way at most
// Notes:   status flags clear by read-as-1 then write-0
`timescale 1ns/1ps
module fur_rx_top
	import fur_pkg::*;
#(
	parameter int unsigned IDLE_LIMIT = IDLE_CYC
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        serial_in_pin,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq_rx_full,
	output logic             irq_rx_err,
	output logic             irq_rx_brk
);
	// ----------------------------------------------------------------
	// line synchroniser and frame receiver
	// ----------------------------------------------------------------
	logic              sync1_q, sync2_q;
	logic              rx_busy, rx_done, rx_ferr, rx_brk;
	logic [DATA_W-1:0] rx_shift;

	// two flops before any logic reads the pin
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= serial_in_pin;
			sync2_q <= sync1_q;
		end
	end

	logic rx_on_q, rx_irq_en_q;

	fur_rx_frame u_frame (
		.clock     (clock),
		.resetn    (resetn),
		.enable    (rx_on_q),
		.line      (sync2_q),
		.busy      (rx_busy),
		.done      (rx_done),
		.data      (rx_shift),
		.frame_err (rx_ferr),
		.brk       (rx_brk)
	);

	// ----------------------------------------------------------------
	// receive fifo
	// ----------------------------------------------------------------
	logic              push_valid, push_ready, pop, head_valid, flush;
	logic [DATA_W-1:0] head;
	logic [LVL_W-1:0]  level;

	// a break frame carries no data; full fifo drops the frame
	assign push_valid = rx_done && !rx_brk;

	fur_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.resetn    (resetn),
		.flush     (flush),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (rx_shift),
		.out_valid (head_valid),
		.out_ready (pop),
		.out_data  (head),
		.level     (level)
	);

	// ----------------------------------------------------------------
	// registers and flags
	// ----------------------------------------------------------------
	logic [1:0]       trig_q, trig_d;
	logic             rx_on_d, rx_irq_en_d;
	logic             full_q, full_d, ready_q, ready_d, err_q, err_d, brk_q, brk_d;
	logic [3:0]       seen_q, seen_d;   // flags read as 1: err, brk, full, ready
	logic [LVL_W-1:0] trig_cnt;
	logic [31:0]      idle_q, idle_d;
	logic             wr_go, rd_go, wr_clr;
	logic [7:0]       wbyte;
	logic             bvalid_d, rvalid_d;
	logic [1:0]       bresp_d, rresp_d;
	logic [31:0]      rdata_d;

	// trigger field to byte count
	always_comb begin
		unique case (trig_q)
			2'h0: trig_cnt = TRIG_CNT_0;
			2'h1: trig_cnt = TRIG_CNT_1;
			2'h2: trig_cnt = TRIG_CNT_2;
			2'h3: trig_cnt = TRIG_CNT_3;
		endcase
	end

	// bus handshakes: write takes address and data together
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;
	assign wbyte         = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'hff;
	assign wr_clr        = wr_go && s_axi_awaddr == OFS_STATUS;
	assign pop           = rd_go && s_axi_araddr == OFS_DATA && head_valid;
	assign flush         = wr_go && s_axi_awaddr == OFS_FCTL && s_axi_wstrb[0]
	                       && s_axi_wdata[BIT_FIFO_RST];

	// separate requests, each gated by the receive interrupt enable; ready shares the full request
	assign irq_rx_full = rx_irq_en_q && (full_q || ready_q);
	assign irq_rx_err  = rx_irq_en_q && err_q;
	assign irq_rx_brk  = rx_irq_en_q && brk_q;

	// register file, flags and bus answers
	always_comb begin
		rx_on_d     = rx_on_q;
		rx_irq_en_d = rx_irq_en_q;
		trig_d      = trig_q;
		seen_d      = seen_q;
		bvalid_d    = s_axi_bvalid && !s_axi_bready;
		bresp_d     = s_axi_bresp;
		rvalid_d    = s_axi_rvalid && !s_axi_rready;
		rresp_d     = s_axi_rresp;
		rdata_d     = s_axi_rdata;
		// idle line counter, held at zero while a frame is received or the fifo is empty
		idle_d      = (rx_busy || rx_done || level == '0) ? '0 :
		              (idle_q == IDLE_LIMIT) ? idle_q : idle_q + 1;
		// write 0 to a flag seen as 1 clears it
		full_d  = full_q  && !(wr_clr && s_axi_wstrb[0] && seen_q[1] && !wbyte[BIT_FULL]);
		ready_d = ready_q && !(wr_clr && s_axi_wstrb[0] && seen_q[0] && !wbyte[BIT_READY]);
		err_d   = err_q   && !(wr_clr && s_axi_wstrb[0] && seen_q[3] && !wbyte[BIT_ERR]);
		brk_d   = brk_q   && !(wr_clr && s_axi_wstrb[0] && seen_q[2] && !wbyte[BIT_BRK]);
		if (wr_clr) begin
			seen_d = '0;
		end
		// hardware sets win over a clear in the same cycle
		if (level >= trig_cnt) begin
			full_d = 1'b1;
		end
		if (idle_q == IDLE_LIMIT && level != '0 && level < trig_cnt) begin
			ready_d = 1'b1;
		end
		if (rx_done && rx_ferr && !rx_brk) begin
			err_d = 1'b1;
		end
		if (rx_done && rx_brk) begin
			brk_d = 1'b1;
		end
		if (wr_go) begin
			bvalid_d = 1'b1;
			bresp_d  = RESP_OK;
			unique case (s_axi_awaddr)
				OFS_CTL: begin
					if (s_axi_wstrb[0]) begin
						rx_irq_en_d = s_axi_wdata[BIT_RX_IRQ_EN];
						rx_on_d     = s_axi_wdata[BIT_RX_ON];
					end
				end
				OFS_FCTL: begin
					if (s_axi_wstrb[0]) begin
						trig_d = s_axi_wdata[POS_TRIG +: 2];
					end
				end
				OFS_STATUS: ;
				default: bresp_d = RESP_ERR;
			endcase
		end
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OK;
			rdata_d  = '0;
			unique case (s_axi_araddr)
				OFS_CTL: begin
					rdata_d[BIT_RX_IRQ_EN] = rx_irq_en_q;
					rdata_d[BIT_RX_ON]     = rx_on_q;
				end
				OFS_FCTL: rdata_d[POS_TRIG +: 2] = trig_q;
				OFS_STATUS: begin
					rdata_d[BIT_ERR]   = err_q;
					rdata_d[BIT_BRK]   = brk_q;
					rdata_d[BIT_FULL]  = full_q;
					rdata_d[BIT_READY] = ready_q;
					seen_d = seen_q | {err_q, brk_q, full_q, ready_q};
				end
				OFS_DATA:  rdata_d[DATA_W-1:0] = head_valid ? head : '0;
				OFS_COUNT: rdata_d[LVL_W-1:0]  = level;
				default:   rresp_d = RESP_ERR;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rx_on_q      <= 1'b0;
			rx_irq_en_q  <= 1'b0;
			trig_q       <= RST_TRIG;
			seen_q       <= '0;
			full_q       <= 1'b0;
			ready_q      <= 1'b0;
			err_q        <= 1'b0;
			brk_q        <= 1'b0;
			idle_q       <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= RESP_OK;
			s_axi_rdata  <= '0;
		end else begin
			rx_on_q      <= rx_on_d;
			rx_irq_en_q  <= rx_irq_en_d;
			trig_q       <= trig_d;
			seen_q       <= seen_d;
			full_q       <= full_d;
			ready_q      <= ready_d;
			err_q        <= err_d;
			brk_q        <= brk_d;
			idle_q       <= idle_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp  <= bresp_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rresp  <= rresp_d;
			s_axi_rdata  <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_push_one: assert property (@(posedge clock) disable iff (!resetn)
		(push_valid && push_ready && !pop && !flush) |=> (level == $past(level) + 5'h01))
		else $error("frame not moved into fifo");
	a_full_drop: assert property (@(posedge clock) disable iff (!resetn)
		(level == 5'h10 && !pop && !flush) |=> (level == 5'h10))
		else $error("fifo level changed while full");
	a_trig_eight: assert property (@(posedge clock) disable iff (!resetn)
		(trig_q == 2'h2) |-> (trig_cnt == 5'h08))
		else $error("trigger 10 not eight bytes");
	a_full_flag: assert property (@(posedge clock) disable iff (!resetn)
		(level >= trig_cnt) |=> full_q ##0 (irq_rx_full || !rx_irq_en_q))
		else $error("full flag or request missing");
	a_irq_gate: assert property (@(posedge clock) disable iff (!resetn)
		!rx_irq_en_q |-> !(irq_rx_full || irq_rx_err || irq_rx_brk))
		else $error("request while disabled");
	a_ready_set: assert property (@(posedge clock) disable iff (!resetn)
		(idle_q == IDLE_LIMIT && level != '0 && level < trig_cnt)
		|=> ready_q && (irq_rx_full || !rx_irq_en_q))
		else $error("ready flag not set on idle leftovers");
	a_clear_seen: assert property (@(posedge clock) disable iff (!resetn)
		$fell(full_q) |-> $past(seen_q[1]) && $past(wr_clr))
		else $error("full flag cleared without read of 1");
	a_ready_wait: assert property (@(posedge clock) disable iff (!resetn)
		$rose(ready_q) |-> $past(idle_q) == IDLE_LIMIT)
		else $error("ready flag before idle time");
	a_brk_src: assert property (@(posedge clock) disable iff (!resetn)
		(rx_done && rx_brk) |=> brk_q && !push_valid)
		else $error("break not flagged separately");
	a_err_src: assert property (@(posedge clock) disable iff (!resetn)
		(rx_done && rx_ferr && !rx_brk) |=> err_q)
		else $error("framing error not flagged");
	a_ready_clear: assert property (@(posedge clock) disable iff (!resetn)
		$fell(ready_q) |-> $past(seen_q[0]) && $past(wr_clr))
		else $error("ready flag cleared without read of 1");
	// a data read takes exactly one byte off the head
	a_data_pop: assert property (@(posedge clock) disable iff (!resetn)
		(pop && !push_valid && !flush) |=> (level == $past(level) - 5'h01))
		else $error("data read did not pop one byte");
endmodule

// >>> src/fur_pkg.sv
// Purpose: shared constants of the serial receive block
// Assumes: 25 MHz clock, fixed 9600 bit/s line, 8N1 frames
// Notes:   register offsets are byte addresses on the AXI4-Lite slave
package fur_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 25000000;
	localparam int unsigned BAUD_BPS    = 9600;
	localparam int unsigned BIT_CYC     = CLK_HZ / BAUD_BPS;  // clock cycles per bit, rounded down
	localparam int unsigned HALF_CYC    = BIT_CYC / 2;
	localparam int unsigned FRAME_BITS  = 10;
	localparam int unsigned IDLE_FRAMES = 2;
	localparam int unsigned IDLE_CYC    = IDLE_FRAMES * FRAME_BITS * BIT_CYC;
	localparam int unsigned CNT_W       = 12;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned FIFO_DEPTH  = 16;
	localparam int unsigned LVL_W       = 5;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTL    = 8'h00;
	localparam logic [7:0] OFS_FCTL   = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_DATA   = 8'h0c;
	localparam logic [7:0] OFS_COUNT  = 8'h10;

	// control word fields
	localparam int unsigned BIT_RX_IRQ_EN = 6;
	localparam int unsigned BIT_RX_ON     = 4;
	// fifo control fields
	localparam int unsigned POS_TRIG      = 6;
	localparam int unsigned BIT_FIFO_RST  = 1;
	// status word fields
	localparam int unsigned BIT_ERR       = 7;
	localparam int unsigned BIT_BRK       = 4;
	localparam int unsigned BIT_FULL      = 1;
	localparam int unsigned BIT_READY     = 0;

	localparam logic [1:0] RST_TRIG = 2'h2;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// trigger field to byte count
	localparam logic [LVL_W-1:0] TRIG_CNT_0 = 5'h01;
	localparam logic [LVL_W-1:0] TRIG_CNT_1 = 5'h04;
	localparam logic [LVL_W-1:0] TRIG_CNT_2 = 5'h08;
	localparam logic [LVL_W-1:0] TRIG_CNT_3 = 5'h0e;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} fur_rx_e;
endpackage

// >>> src/fur_fifo.sv
// Purpose: first-in first-out buffer with valid/ready on both sides
// Assumes: flush has priority over push and pop
// Notes:   out_data is the head entry held in storage flops
`timescale 1ns/1ps
module fur_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic                       clock,
	input  wire logic                       resetn,
	input  wire logic                       flush,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [W-1:0]                    out_data,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned LW = $clog2(DEPTH+1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [W-1:0]  mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [LW-1:0] lvl_q, lvl_d;
	logic          push, pop;

	// honest full and empty flags
	assign in_ready  = (lvl_q != LW'(DEPTH));
	assign out_valid = (lvl_q != '0);
	assign out_data  = mem_q[rd_q];
	assign level     = lvl_q;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and storage next state
	always_comb begin
		mem_d = mem_q;
		wr_d  = wr_q;
		rd_d  = rd_q;
		lvl_d = lvl_q;
		if (flush) begin
			wr_d  = '0;
			rd_d  = '0;
			lvl_d = '0;
		end else begin
			if (push) begin
				mem_d[wr_q] = in_data;
				wr_d        = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			lvl_d = lvl_q + LW'(push) - LW'(pop);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wr_q  <= '0;
			rd_q  <= '0;
			lvl_q <= '0;
		end else begin
			mem_q <= mem_d;
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			lvl_q <= lvl_d;
		end
	end
endmodule

// >>> src/fur_rx_frame.sv
// Purpose: start-bit detection and 8N1 frame assembly
// Assumes: line input already synchronised to clock
// Notes:   done pulses once per frame with data, error and break
`timescale 1ns/1ps
module fur_rx_frame
	import fur_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              enable,
	input  wire logic              line,
	output logic                   busy,
	output logic                   done,
	output logic [DATA_W-1:0]      data,
	output logic                   frame_err,
	output logic                   brk
);
	fur_rx_e           st_q, st_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [2:0]        idx_q, idx_d;
	logic [DATA_W-1:0] shift_q, shift_d;
	logic              done_q, done_d, err_q, err_d, brk_q, brk_d;

	assign busy      = (st_q != RX_IDLE);
	assign done      = done_q;
	assign data      = shift_q;
	assign frame_err = err_q;
	assign brk       = brk_q;

	// frame sequencer
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q + 1'b1;
		idx_d   = idx_q;
		shift_d = shift_q;
		done_d  = 1'b0;
		err_d   = err_q;
		brk_d   = brk_q;
		unique case (st_q)
			RX_IDLE: begin
				cnt_d = '0;
				if (enable && !line) begin
					st_d = RX_START;
				end
			end
			RX_START: begin
				if (cnt_q == CNT_W'(HALF_CYC)) begin
					cnt_d = '0;
					idx_d = '0;
					st_d  = line ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (cnt_q == CNT_W'(BIT_CYC - 1)) begin
					cnt_d   = '0;
					shift_d = {line, shift_q[DATA_W-1:1]};
					idx_d   = idx_q + 1'b1;
					if (idx_q == 3'h7) begin
						st_d = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (cnt_q == CNT_W'(BIT_CYC - 1)) begin
					st_d   = RX_IDLE;
					done_d = 1'b1;
					err_d  = !line;
					brk_d  = !line && (shift_q == '0);
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q    <= RX_IDLE;
			cnt_q   <= '0;
			idx_q   <= '0;
			shift_q <= '0;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
			brk_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			idx_q   <= idx_d;
			shift_q <= shift_d;
			done_q  <= done_d;
			err_q   <= err_d;
			brk_q   <= brk_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_start_detect: assert property (@(posedge clock) disable iff (!resetn)
		(st_q == RX_IDLE && enable && !line) |=> (st_q == RX_START))
		else $error("start bit not taken");
	a_lsb_first: assert property (@(posedge clock) disable iff (!resetn)
		(st_q == RX_DATA && cnt_q == CNT_W'(BIT_CYC - 1))
		|=> (shift_q[DATA_W-1] == $past(line)))
		else $error("data bit not shifted in at top");
endmodule

// >>> tb/fur_tx_model.sv
// Purpose: remote asynchronous transmitter driving the serial line
// Assumes: 8N1 frames at the package bit time, line idles high
// Notes:   stop_bit low gives a framing error or, with data 0, a break
`timescale 1ns/1ps
module fur_tx_model
	import fur_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic [7:0] byte_in,
	input  wire logic       stop_bit,
	output logic            line,
	output logic            busy
);
	logic [9:0] frame;

	initial begin
		line = 1'b1;
		busy = 1'b0;
	end

	// ----------------------------------------------------------------
	// frame sender
	// ----------------------------------------------------------------
	// start bit low, data lsb first, then stop bit
	always begin
		@(posedge clock);
		if (go) begin
			busy <= 1'b1;
			frame = {stop_bit, byte_in, 1'b0};
			for (int i = 0; i < 10; i++) begin
				line <= frame[i];
				repeat (BIT_CYC) @(posedge clock);
			end
			line <= 1'b1; // idle level between frames
			busy <= 1'b0;
		end
	end
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench of the serial receive block
// Assumes: AXI4-Lite master tasks, one frame at a time on the line
// Notes:   idle limit shortened; bit time stays at the package value
`timescale 1ns/1ps
module tb
	import fur_pkg::*;
;
	localparam int unsigned IDLE_T = 2000;
	localparam logic [31:0] ST_FULL = 32'h1 << BIT_FULL;
	localparam logic [31:0] ST_RDY  = 32'h1 << BIT_READY;
	localparam logic [31:0] ST_BRK  = 32'h1 << BIT_BRK;
	localparam logic [31:0] ST_ERR  = 32'h1 << BIT_ERR;
	localparam logic [31:0] C_ON    = 32'h1 << BIT_RX_ON;
	localparam logic [31:0] C_IRQ   = 32'h1 << BIT_RX_IRQ_EN;

	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	wire logic   serial_in_pin;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        irq_rx_full, irq_rx_err, irq_rx_brk;
	logic        go = 1'b0;
	logic [7:0]  tx_byte = 8'h00;
	logic        tx_stop = 1'b1;
	logic        busy;
	logic [7:0]  b1, b2;
	int          err_count = 0;
	int          num_checks = 0;

	fur_rx_top #(.IDLE_LIMIT(IDLE_T)) u_dut (.clock, .resetn, .serial_in_pin,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq_rx_full, .irq_rx_err, .irq_rx_brk);

	fur_tx_model u_tx (.clock, .go, .byte_in(tx_byte), .stop_bit(tx_stop),
		.line(serial_in_pin), .busy);

	// ----------------------------------------------------------------
	// clock and helpers
	// ----------------------------------------------------------------
	initial begin
		forever #20 clock = ~clock;
	end

	// expected response from the register map
	function automatic logic [31:0] exp_resp(input logic [7:0] a);
		return {30'h0, (a > OFS_COUNT) ? RESP_ERR : RESP_OK};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// write with check of the response code
	task automatic wc(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge clock); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge clock); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, exp_resp(a));
		@(posedge clock);
	endtask

	// read with check of data and response code
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clock); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clock); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, exp_resp(a));
		@(posedge clock);
	endtask

	// one frame on the line, returns once the sender is idle again
	task automatic send(input logic [7:0] b, input logic s);
		go <= 1'b1;
		tx_byte <= b;
		tx_stop <= s;
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		while (busy) @(posedge clock);
		repeat (10) @(posedge clock);
	endtask

	task automatic irqs(input logic [2:0] e);
		chk({29'h0, irq_rx_full, irq_rx_err, irq_rx_brk}, {29'h0, e});
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (100000) @(posedge clock);
		err_count++;
		final_report();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h8686));
		b1 = 8'($urandom) | 8'h01;  // never zero, so a low stop bit is no break
		b2 = 8'($urandom);
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		// reset values and unmapped places
		rc(OFS_CTL, 32'h0);
		rc(OFS_FCTL, {24'h0, RST_TRIG, 6'h0});
		rc(OFS_STATUS, 32'h0);
		rc(OFS_COUNT, 32'h0);
		rc(8'h14, 32'h0);
		wc(8'h18, 32'hff);
		$display("test reset done");

		// trigger of one byte, request gated by the enable, stop bit low
		wc(OFS_FCTL, 32'h0);
		wc(OFS_CTL, C_ON);
		send(b1, 1'b0);
		irqs(3'b000);
		wc(OFS_CTL, C_ON | C_IRQ);
		irqs(3'b110);
		rc(OFS_COUNT, 32'h1);
		rc(OFS_STATUS, ST_FULL | ST_ERR);
		wc(OFS_STATUS, 32'h0);
		irqs(3'b100);
		rc(OFS_DATA, {24'h0, b1});
		rc(OFS_STATUS, ST_FULL);
		wc(OFS_STATUS, 32'h0);
		rc(OFS_STATUS, 32'h0);
		irqs(3'b000);
		$display("test full done");

		// leftover byte below a trigger of four
		wc(OFS_FCTL, 32'h40);
		rc(OFS_FCTL, 32'h40);
		send(b2, 1'b1);
		irqs(3'b000);
		repeat (IDLE_T / 2) @(posedge clock);
		irqs(3'b100);
		wc(OFS_STATUS, 32'h0);
		rc(OFS_STATUS, ST_RDY);
		rc(OFS_DATA, {24'h0, b2});
		rc(OFS_STATUS, ST_RDY);
		wc(OFS_STATUS, 32'h0);
		rc(OFS_STATUS, 32'h0);
		irqs(3'b000);
		$display("test ready done");

		// break frame is flagged and not stored
		send(8'h00, 1'b0);
		irqs(3'b001);
		rc(OFS_STATUS, ST_BRK);
		rc(OFS_COUNT, 32'h0);
		rc(OFS_CTL, C_ON | C_IRQ);
		wc(OFS_CTL, 32'h0);
		irqs(3'b000);
		$display("test break done");
		final_report();
	end
endmodule
